// >>> design/fpe_cfg.svh
// Constants for the four-bit port with shared clear pin.
// Assumes inclusion by bare name from design files only.
`ifndef FPE_CFG_SVH
`define FPE_CFG_SVH
`define FPE_BIDIR_W        3
`define FPE_PORT_W         4
`define FPE_DIR_W          8
`define FPE_PULLUP_BIT     7
`define FPE_INPUT_BIT      3
`define FPE_DIR_RESET      8'h07
`define FPE_LATCH_RESET    3'h0
`define FPE_ANALOG_RESET   3'h7
`define FPE_SYNC_STAGES    2
`endif

// >>> design/fpe_pkg.sv
// Types for the four-bit port with shared clear pin.
// Assumes fpe_cfg.svh is on the include path.
`include "fpe_cfg.svh"
package fpe_pkg;
  // Configuration word bits that shape the fourth pin and, through largePackage, the three bidirectional pins.
  typedef struct packed {
    logic masterClearEnable;
    logic lowVoltageProgramEnable;
    logic largePackage;
  } fpe_config_s;
  // Software writes: strobes with their data.
  typedef struct packed {
    logic                      dirWrite;
    logic [`FPE_DIR_W-1:0]     dirData;
    logic                      latchWrite;
    logic [`FPE_BIDIR_W-1:0]   latchData;
    logic                      analogWrite;
    logic [`FPE_BIDIR_W-1:0]   analogData;
  } fpe_write_s;
endpackage : fpe_pkg

// >>> design/fpe_port.sv
// Four-bit general-purpose port: three bidirectional pins and one input-only pin
// shared with master clear and programming voltage. Registers are plain ports.
// Assumes pins are synchronous-safe after the internal synchroniser.
`timescale 1ns/1ps
`default_nettype none
`include "fpe_cfg.svh"
module fpe_port #(
  parameter int BIDIR_W = `FPE_BIDIR_W
) (
  input  wire logic                         clk,
  input  wire logic                         rstn,
  input  wire fpe_pkg::fpe_config_s         cfg,
  input  wire fpe_pkg::fpe_write_s          wr,
  input  wire logic                         globalPullupDisable,
  input  wire logic [7:0]                   otherPortPullupBits,
  input  wire logic                         programmingActive,
  input  wire logic [BIDIR_W-1:0]           bidirPinsIn,
  input  wire logic                         inputOnlyPin,
  output logic      [BIDIR_W-1:0]           bidirPinsOut,
  output logic      [BIDIR_W-1:0]           bidirPinsOe,
  output logic      [`FPE_PORT_W-1:0]       fourthPortValue,
  output logic      [`FPE_DIR_W-1:0]        directionRegE,
  output logic      [BIDIR_W-1:0]           latchRegE,
  output logic      [BIDIR_W-1:0]           analogSelectRegE,
  output logic                              pin3PullupOn,
  output logic      [7:0]                   otherPortPullupOn,
  output logic                              masterClearInputN,
  output logic                              programmingVoltageSel,
  output logic                              portPresent
);

  // Software-visible state.
  logic [`FPE_DIR_W-1:0]   dir_reg, dir_next;
  logic [BIDIR_W-1:0]      lat_reg, lat_next;
  logic [BIDIR_W-1:0]      ans_reg, ans_next;
  // Synchroniser stages and registered outputs.
  logic [`FPE_PORT_W-1:0]  syncA_reg, syncB_reg;
  logic [`FPE_PORT_W-1:0]  portVal_reg, portVal_next;
  logic [BIDIR_W-1:0]      out_reg, out_next, oe_reg, oe_next;
  logic                    pu3_reg, pu3_next;
  logic [7:0]              puB_reg, puB_next;
  logic                    master_clear_input_reg, master_clear_input_next;
  logic                    vpp_reg, vpp_next;
  logic                    present_reg, present_next;
  logic                    forcePu;

  // Next values of the software registers; bits 6:3 of direction are unimplemented.
  always_comb begin
    dir_next = dir_reg;
    lat_next = lat_reg;
    ans_next = ans_reg;
    if (wr.dirWrite) begin
      dir_next = {wr.dirData[`FPE_PULLUP_BIT], 4'h0, wr.dirData[BIDIR_W-1:0]};
    end
    if (wr.latchWrite) begin
      lat_next = wr.latchData;
    end
    if (wr.analogWrite) begin
      ans_next = wr.analogData;
    end
  end

  // Fourth pin pull-up is forced by the clear or low-voltage programming setup.
  assign forcePu = (cfg.masterClearEnable & ~cfg.lowVoltageProgramEnable) | cfg.lowVoltageProgramEnable;

  // Pin drive, read value, pull-ups and fourth-pin function selection.
  always_comb begin
    out_next  = lat_reg;
    oe_next   = ~dir_reg[BIDIR_W-1:0];
    if (!cfg.largePackage) begin
      oe_next = '0;
    end
    portVal_next = '0;
    if (cfg.largePackage) begin
      portVal_next[BIDIR_W-1:0] = syncB_reg[BIDIR_W-1:0] & ~ans_reg;
    end
    if (!cfg.masterClearEnable) begin
      portVal_next[`FPE_INPUT_BIT] = syncB_reg[`FPE_INPUT_BIT];
    end
    pu3_next  = forcePu | (dir_reg[`FPE_PULLUP_BIT] & ~globalPullupDisable);
    puB_next  = otherPortPullupBits & {8{~globalPullupDisable}};
    master_clear_input_next = cfg.masterClearEnable ? syncB_reg[`FPE_INPUT_BIT] : 1'b1;
    vpp_next  = programmingActive;
    present_next = cfg.largePackage | ~cfg.masterClearEnable;
  end

  // Registers; reset makes bidirectional pins analog inputs with pull-ups off.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dir_reg     <= `FPE_DIR_RESET;
      lat_reg     <= `FPE_LATCH_RESET;
      ans_reg     <= `FPE_ANALOG_RESET;
      syncA_reg   <= '0;
      syncB_reg   <= '0;
      portVal_reg <= '0;
      out_reg     <= '0;
      oe_reg      <= '0;
      pu3_reg     <= 1'b0;
      puB_reg     <= 8'h00;
      master_clear_input_reg    <= 1'b1;
      vpp_reg     <= 1'b0;
      present_reg <= 1'b0;
    end else begin
      dir_reg     <= dir_next;
      lat_reg     <= lat_next;
      ans_reg     <= ans_next;
      syncA_reg   <= {inputOnlyPin, bidirPinsIn};
      syncB_reg   <= syncA_reg;
      portVal_reg <= portVal_next;
      out_reg     <= out_next;
      oe_reg      <= oe_next;
      pu3_reg     <= pu3_next;
      puB_reg     <= puB_next;
      master_clear_input_reg    <= master_clear_input_next;
      vpp_reg     <= vpp_next;
      present_reg <= present_next;
    end
  end

  // Outputs straight from flip-flops.
  assign bidirPinsOut          = out_reg;
  assign bidirPinsOe           = oe_reg;
  assign fourthPortValue       = portVal_reg;
  assign directionRegE         = dir_reg;
  assign latchRegE             = lat_reg;
  assign analogSelectRegE      = ans_reg;
  assign pin3PullupOn          = pu3_reg;
  assign otherPortPullupOn     = puB_reg;
  assign masterClearInputN     = master_clear_input_reg;
  assign programmingVoltageSel = vpp_reg;
  assign portPresent           = present_reg;

endmodule : fpe_port
`default_nettype wire

// >>> verif/fpe_port_chk.sv
// Port checker: watches only the top ports of the block.
// Assumes fpe_pkg is compiled before it.
`timescale 1ns/1ps
`default_nettype none
module fpe_port_chk (
  input wire logic               clk, rstn, globalPullupDisable, programmingActive,
  input wire fpe_pkg::fpe_config_s cfg,
  input wire fpe_pkg::fpe_write_s  wr,
  input wire logic [2:0]         bidirPinsOut, bidirPinsOe, latchRegE, analogSelectRegE,
  input wire logic [3:0]         fourthPortValue,
  input wire logic [7:0]         directionRegE,
  input wire logic               pin3PullupOn, masterClearInputN, programmingVoltageSel, portPresent,
  input wire logic               inputOnlyPin,
  input wire logic [7:0]         otherPortPullupBits, otherPortPullupOn
);
  // One clock domain, so clocking and reset are declared once.
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_oe_dir: assert property ($past(cfg.largePackage) |-> bidirPinsOe == ~$past(directionRegE[2:0]))
    else $error("oe differs");
  a_out_latch: assert property (bidirPinsOut == $past(latchRegE))
    else $error("out differs");
  a_dir_wr: assert property (wr.dirWrite |=> directionRegE == ($past(wr.dirData) & 8'h87))
    else $error("dir differs");
  a_latch_wr: assert property (wr.latchWrite |=> latchRegE == $past(wr.latchData))
    else $error("latch differs");
  a_ana_zero: assert property ((fourthPortValue[2:0] & analogSelectRegE & $past(analogSelectRegE)) == 3'h0)
    else $error("analog bit read");
  a_pullup_rule: assert property ($past(rstn) |-> pin3PullupOn == $past(cfg.lowVoltageProgramEnable
    | cfg.masterClearEnable | (directionRegE[7] & !globalPullupDisable)))
    else $error("pullup differs");
  a_master_clear_input_off: assert property (!cfg.masterClearEnable |=> masterClearInputN)
    else $error("clear asserted");
  a_vpp_copy: assert property ($past(rstn) |-> programmingVoltageSel == $past(programmingActive))
    else $error("vpp differs");
  a_port_exists: assert property ($past(rstn) |-> portPresent == $past(cfg.largePackage | !cfg.masterClearEnable))
    else $error("present differs");
  a_master_clear_input_pin: assert property (($past(rstn, 3) && $past(cfg.masterClearEnable)) |-> masterClearInputN == $past(inputOnlyPin, 3))
    else $error("clear input differs");
  a_other_pullup: assert property ($past(rstn) |-> otherPortPullupOn == ($past(otherPortPullupBits) & ~{8{$past(globalPullupDisable)}}))
    else $error("other pullup differs");
  a_ana_wr: assert property (wr.analogWrite |=> analogSelectRegE == $past(wr.analogData))
    else $error("analog select differs");
endmodule : fpe_port_chk
bind fpe_port fpe_port_chk fpe_port_chk_inst (.*);
`default_nettype wire

// >>> verif/fpe_board.sv
// Board model for the three bidirectional pins.
// Assumes the bench supplies the level of released pins.
`timescale 1ns/1ps
`default_nettype none
module fpe_board (
  input  wire logic [2:0] pinOut, pinOe, extLevel,
  output logic      [2:0] pinLevel
);
  // A driving port wins; a released pin follows the board source.
  assign pinLevel = (pinOut & pinOe) | (extLevel & ~pinOe);
endmodule : fpe_board
`default_nettype wire

// >>> verif/fpe_port_tb_top.sv
// Self-checking bench for the four-bit port.
// Assumes design, board model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module fpe_port_tb_top;
  logic clk = 0, rstn = 0, globalPullupDisable = 0, programmingActive = 0, inputOnlyPin = 1;
  logic pin3PullupOn, masterClearInputN, programmingVoltageSel, portPresent;
  fpe_pkg::fpe_config_s cfg = 3'h1;
  fpe_pkg::fpe_write_s  wr = '0;
  logic [7:0] otherPortPullupBits = 8'hA5, otherPortPullupOn, directionRegE, expQ[$];
  logic [2:0] bidirPinsIn, bidirPinsOut, bidirPinsOe, latchRegE, analogSelectRegE, ext = 3'h0, d, l;
  logic [3:0] fourthPortValue;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  fpe_port fpe_port_inst (.*);
  fpe_board fpe_board_inst (.pinOut(bidirPinsOut), .pinOe(bidirPinsOe), .extLevel(ext), .pinLevel(bidirPinsIn));
  always #2.5 clk = ~clk;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD portView exp %h seen %h", exp, seen);
    end
  endtask : check
  task automatic print_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  // Writes all three registers at once, then waits for pins to settle.
  task automatic wrt(input logic [7:0] dd, input logic [2:0] ll, input logic [2:0] aa);
    wr <= '{1'b1, dd, 1'b1, ll, 1'b1, aa};
    @(posedge clk) wr <= '0;
    repeat (6) @(posedge clk);
  endtask : wrt
  // Compares pull-up, drivers and read value with the oldest note.
  always @(negedge clk) if (expQ.size() > 0) check({pin3PullupOn, bidirPinsOe, fourthPortValue}, expQ.pop_front());
  // Cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // Main sequence.
  initial begin
    void'($urandom(98849));
    repeat (20) @(posedge clk);
    rstn <= 1;
    repeat (3) @(posedge clk);
    expQ.push_back(8'h08);
    for (int i = 0; i < 8; i++) begin
      d = 3'($urandom);
      l = 3'($urandom);
      ext <= 3'($urandom);
      inputOnlyPin <= 1'($urandom);
      otherPortPullupBits <= 8'($urandom);
      wrt({1'b1, 4'($urandom), d}, l, 3'h0);
      expQ.push_back({1'b1, ~d, inputOnlyPin, (l & ~d) | (ext & d)});
    end
    globalPullupDisable <= 1;
    wrt(8'h80, 3'h5, 3'h7);
    expQ.push_back({1'b0, 3'h7, inputOnlyPin, 3'h0});
    // Analog pins kept as inputs while analog is in use, as software must.
    wrt(8'h07, 3'h5, 3'h7);
    expQ.push_back({1'b0, 3'h0, inputOnlyPin, 3'h0});
    cfg <= 3'h3;
    programmingActive <= 1;
    wrt(8'h87, 3'h0, 3'h0);
    expQ.push_back({1'b1, 3'h0, inputOnlyPin, ext});
    cfg <= 3'h5;
    wrt(8'h07, 3'h0, 3'h0);
    expQ.push_back({1'b1, 3'h0, 1'b0, ext});
    cfg <= 3'h4;
    wrt(8'h07, 3'h0, 3'h0);
    expQ.push_back({1'b1, 3'h0, 1'b0, 3'h0});
    repeat (2) @(posedge clk);
    print_verdict();
  end
endmodule : fpe_port_tb_top
`default_nettype wire
